// ===== flash_seq_pkg.sv
// Purpose: shared constants for the flash command sequencer
// Assumes: 32-bit APB with a 12-bit byte address
// Notes:   command codes are the low byte of a 16-bit command write
package flash_seq_pkg;

    // apb map
    localparam logic [11:0] CTRL_A_OFS = 12'h000;
    localparam logic [11:0] CTRL_B_OFS = 12'h004;
    localparam logic [11:0] ROM_BASE   = 12'h800;

    // flash_control_reg_a fields
    localparam int READY_BIT      = 0;
    localparam int REWRITE_EN_BIT = 1;
    localparam int LOCK_DIS_BIT   = 2;
    localparam int PROG_ERR_BIT   = 6;
    localparam int ERASE_ERR_BIT  = 7;

    // flash_control_reg_b fields
    localparam int RESIDENT_BIT   = 1;
    localparam int LOCK_RES_BIT   = 6;

    // status_byte fields
    localparam int SR_READY_BIT   = 7;
    localparam int SR_ERASE_BIT   = 5;
    localparam int SR_PROG_BIT    = 4;

    // command codes
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM      = 8'h40;
    localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL    = 8'ha7;
    localparam logic [7:0] CMD_LOCK_PROG    = 8'h77;
    localparam logic [7:0] CMD_LOCK_READ    = 8'h71;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;

    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // array geometry and operation lengths
    localparam int NUM_BLOCKS_DEF   = 8;
    localparam int BLOCK_WORDS_DEF  = 16;
    localparam int PROG_CYCLES_DEF  = 16;
    localparam int ERASE_CYCLES_DEF = 32;
    localparam int LOCK_CYCLES_DEF  = 4;

    typedef enum logic [2:0] {
        OP_PROGRAM,
        OP_ERASE,
        OP_ERASE_ALL,
        OP_LOCK_PROG,
        OP_LOCK_READ
    } flash_op_t;

endpackage : flash_seq_pkg

// ===== flash_op_if.sv
`timescale 1ns/10ps
// Purpose: operation request and result between sequencer and array
// Assumes: one clock; only busy, done, fail, lock_res and lock_dis are registered on it
// Notes:   addr_locked refers to the block holding addr
interface flash_op_if #(parameter int AW = 7);
    import flash_seq_pkg::*;
    logic            start;
    flash_op_t       op;
    logic [AW-1:0]   addr;
    logic [15:0]     wdata;
    logic            lock_dis;
    logic [AW-1:0]   raddr;
    logic            busy;
    logic            done;
    logic            fail;
    logic            lock_res;
    logic [15:0]     rdata;
    logic            addr_locked;

    modport seq  (output start, op, addr, wdata, lock_dis, raddr,
                  input  busy, done, fail, lock_res, rdata, addr_locked);
    modport core (input  start, op, addr, wdata, lock_dis, raddr,
                  output busy, done, fail, lock_res, rdata, addr_locked);
endinterface : flash_op_if

// ===== flash_array_core.sv
`timescale 1ns/10ps
// Purpose: flash array model with lock bits and timed auto operations
// Assumes: requests arrive only while not busy
// Notes:   i_verify_fail makes a running program, lock program or erase end in error
module flash_array_core
    import flash_seq_pkg::*;
#(
    parameter int NUM_BLOCKS   = NUM_BLOCKS_DEF,
    parameter int BLOCK_WORDS  = BLOCK_WORDS_DEF,
    parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
    parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
    parameter int LOCK_CYCLES  = LOCK_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    // fault injection
    input  wire logic  i_verify_fail,
    // sequencer side
    flash_op_if.core   f
);
    localparam int BW  = $clog2(BLOCK_WORDS);
    localparam int AW  = $clog2(NUM_BLOCKS * BLOCK_WORDS);
    localparam int BKW = $clog2(NUM_BLOCKS);
    localparam logic [BKW-1:0] LAST_ALL = BKW'(NUM_BLOCKS - 2);

    typedef struct packed {
        logic [NUM_BLOCKS*BLOCK_WORDS-1:0][15:0] mem;
        logic [NUM_BLOCKS-1:0]                   lock;
        logic                                    busy;
        logic                                    done;
        logic                                    fail;
        logic                                    lock_res;
        flash_op_t                               op;
        logic [AW-1:0]                           addr;
        logic [15:0]                             wdata;
        logic [15:0]                             cnt;
        logic [BKW-1:0]                          blk;
    } core_t;

    core_t r_reg;
    core_t r_next;

    function automatic logic [15:0] op_len(input flash_op_t o);
        unique case (o)
            OP_PROGRAM:              op_len = 16'(PROG_CYCLES - 1);
            OP_ERASE, OP_ERASE_ALL:  op_len = 16'(ERASE_CYCLES - 1);
            OP_LOCK_PROG, OP_LOCK_READ: op_len = 16'(LOCK_CYCLES - 1);
        endcase
    endfunction : op_len

    always_comb
    begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (!r_reg.busy)
        begin
            if (f.start)
            begin
                r_next.busy  = 1'b1;
                r_next.op    = f.op;
                r_next.addr  = f.addr;
                r_next.wdata = f.wdata;
                r_next.fail  = 1'b0;
                r_next.cnt   = op_len(f.op);
                r_next.blk   = (f.op == OP_ERASE_ALL) ? '0 : f.addr[AW-1:BW];
            end
        end
        else if (r_reg.cnt != 16'h0000)
            r_next.cnt = r_reg.cnt - 16'h0001;
        else
        begin
            unique case (r_reg.op)
                OP_PROGRAM:
                    // a word already programmed stays as it is
                    if (r_reg.mem[r_reg.addr] != ERASED_WORD || i_verify_fail)
                        r_next.fail = 1'b1;
                    else
                        r_next.mem[r_reg.addr] = r_reg.wdata;
                OP_LOCK_PROG:
                    if (i_verify_fail)
                        r_next.fail = 1'b1;
                    else
                        r_next.lock[r_reg.blk] = 1'b0;
                OP_LOCK_READ:
                    r_next.lock_res = r_reg.lock[r_reg.blk];
                OP_ERASE, OP_ERASE_ALL:
                begin
                    // erase-all skips locked blocks unless protection is off
                    if (r_reg.op == OP_ERASE || f.lock_dis ||
                        r_reg.lock[r_reg.blk])
                    begin
                        for (int w = 0; w < BLOCK_WORDS; w++)
                            r_next.mem[{r_reg.blk, w[BW-1:0]}] = ERASED_WORD;
                        r_next.lock[r_reg.blk] = 1'b1;
                    end
                    r_next.fail = r_reg.fail | i_verify_fail;
                end
            endcase
            if (r_reg.op == OP_ERASE_ALL && r_reg.blk != LAST_ALL)
            begin
                r_next.blk = r_reg.blk + 1'b1;
                r_next.cnt = op_len(OP_ERASE_ALL);
            end
            else
            begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_reg      <= '0;
            r_reg.mem  <= '1;
            r_reg.lock <= '1;
        end
        else
            r_reg <= r_next;
    end

    assign f.busy        = r_reg.busy;
    assign f.done        = r_reg.done;
    assign f.fail        = r_reg.fail;
    assign f.lock_res    = r_reg.lock_res;
    assign f.rdata       = r_reg.mem[f.raddr];
    assign f.addr_locked = ~r_reg.lock[f.addr[AW-1:BW]];

    lock_rise_a:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (r_reg.lock & ~$past(r_reg.lock)) != '0
        |-> $past(r_reg.op) inside {OP_ERASE, OP_ERASE_ALL})
    else $error("lock bit rose without an erase");

    no_overwrite_a:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        r_reg.busy && r_reg.op == OP_PROGRAM && r_reg.cnt == 16'h0000
        && r_reg.mem[r_reg.addr] != ERASED_WORD
        |=> r_reg.fail && r_reg.mem[$past(r_reg.addr)] == $past(
            r_reg.mem[r_reg.addr]))
    else $error("programmed word was changed");

endmodule : flash_array_core

// ===== flash_command_sequencer.sv
// Purpose: command decoder for flash rewrite, reached over APB
// Assumes: zero-wait APB slave; flash words are one APB word each
// Notes:   upper half of a command write is ignored
`timescale 1ns/10ps
module flash_command_sequencer
    import flash_seq_pkg::*;
#(
    parameter int NUM_BLOCKS   = NUM_BLOCKS_DEF,
    parameter int BLOCK_WORDS  = BLOCK_WORDS_DEF,
    parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
    parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
    parameter int LOCK_CYCLES  = LOCK_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_resetn,
    // apb slave
    input  wire logic         i_psel,
    input  wire logic         i_penable,
    input  wire logic         i_pwrite,
    input  wire logic [11:0]  i_paddr,
    input  wire logic [31:0]  i_pwdata,
    output logic      [31:0]  o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    // array fault injection
    input  wire logic         i_verify_fail
);
    localparam int AW        = $clog2(NUM_BLOCKS * BLOCK_WORDS);
    localparam int ROM_BYTES = NUM_BLOCKS * BLOCK_WORDS * 4;

    typedef enum logic {S_IDLE, S_SECOND} seq_state_t;
    typedef enum logic {RM_ARRAY, RM_STATUS} read_mode_t;

    typedef struct packed {
        seq_state_t     seq;
        logic [7:0]     cmd1;
        read_mode_t     rmode;
        logic           rewrite_en;
        logic           lock_dis;
        logic           resident;
        logic           prog_err;
        logic           erase_err;
        flash_op_t      last_op;
        logic [31:0]    prdata;
        logic           pslverr;
    } st_t;

    st_t            r_reg;
    st_t            r_next;
    logic [1:0]     rst_sync_reg;
    logic           rst_n;
    logic           setup;
    logic           wr;
    logic           hit_a;
    logic           hit_b;
    logic           hit_rom;
    logic           mapped;
    logic [AW-1:0]  widx;
    logic [7:0]     code;
    logic           ready;
    logic [7:0]     status_byte;
    logic           rom_wr;
    logic           req;
    flash_op_t      rop;
    logic           start;
    logic           seq_bad;
    logic           locked_hit;
    logic           clr_cmd;

    flash_op_if #(.AW(AW)) f ();

    flash_array_core #(
        .NUM_BLOCKS   (NUM_BLOCKS),
        .BLOCK_WORDS  (BLOCK_WORDS),
        .PROG_CYCLES  (PROG_CYCLES),
        .ERASE_CYCLES (ERASE_CYCLES),
        .LOCK_CYCLES  (LOCK_CYCLES)
    ) u_core (
        .i_clk         (i_ref_clk),
        .i_rst_n       (rst_n),
        .i_verify_fail (i_verify_fail),
        .f             (f.core)
    );

    // reset is released through two flops
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    assign setup   = i_psel & ~i_penable;
    assign hit_a   = i_paddr == CTRL_A_OFS;
    assign hit_b   = i_paddr == CTRL_B_OFS;
    assign hit_rom = i_paddr >= ROM_BASE &&
                     int'(i_paddr) < int'(ROM_BASE) + ROM_BYTES &&
                     i_paddr[1:0] == 2'b00;
    assign mapped  = hit_a | hit_b | hit_rom;
    assign wr      = i_psel & i_penable & i_pwrite & mapped;
    assign widx    = i_paddr[AW+1:2];
    assign code    = i_pwdata[7:0];
    assign ready   = ~f.busy;

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[SR_READY_BIT] = ready;
        status_byte[SR_ERASE_BIT] = r_reg.erase_err;
        status_byte[SR_PROG_BIT]  = r_reg.prog_err;
    end

    // ignore flash writes while an operation runs
    assign rom_wr = wr & hit_rom & r_reg.rewrite_en & ~f.busy;

    always_comb
    begin
        r_next     = r_reg;
        req        = 1'b0;
        rop        = OP_PROGRAM;
        start      = 1'b0;
        seq_bad    = 1'b0;
        locked_hit = 1'b0;
        clr_cmd    = 1'b0;

        // answer is prepared in the setup cycle
        if (setup)
        begin
            r_next.pslverr = ~mapped;
            r_next.prdata  = 32'h0000_0000;
            if (hit_a)
            begin
                r_next.prdata[READY_BIT]      = ready;
                r_next.prdata[REWRITE_EN_BIT] = r_reg.rewrite_en;
                r_next.prdata[LOCK_DIS_BIT]   = r_reg.lock_dis;
                r_next.prdata[PROG_ERR_BIT]   = r_reg.prog_err;
                r_next.prdata[ERASE_ERR_BIT]  = r_reg.erase_err;
            end
            else if (hit_b)
            begin
                r_next.prdata[RESIDENT_BIT] = r_reg.resident;
                r_next.prdata[LOCK_RES_BIT] = f.lock_res;
            end
            else if (hit_rom)
            begin
                if (r_reg.rewrite_en && r_reg.rmode == RM_STATUS)
                    r_next.prdata[7:0] = status_byte;
                else
                    r_next.prdata[15:0] = f.rdata;
            end
        end

        if (wr && hit_a)
        begin
            r_next.rewrite_en = i_pwdata[REWRITE_EN_BIT];
            r_next.lock_dis   = i_pwdata[LOCK_DIS_BIT];
            if (!i_pwdata[REWRITE_EN_BIT])
                r_next.resident = 1'b0;
        end
        if (wr && hit_b)
            r_next.resident = i_pwdata[RESIDENT_BIT];

        if (rom_wr)
        begin
            unique case (r_reg.seq)
                S_IDLE:
                    case (code)
                        CMD_READ_ARRAY:
                            r_next.rmode = RM_ARRAY;
                        CMD_READ_STATUS:
                            r_next.rmode = RM_STATUS;
                        CMD_CLEAR_STATUS:
                            clr_cmd = 1'b1;
                        CMD_LOCK_READ:
                        begin
                            r_next.rmode = RM_ARRAY;
                            r_next.seq   = S_SECOND;
                            r_next.cmd1  = code;
                        end
                        CMD_PROGRAM, CMD_BLOCK_ERASE,
                        CMD_ERASE_ALL, CMD_LOCK_PROG:
                        begin
                            r_next.seq  = S_SECOND;
                            r_next.cmd1 = code;
                        end
                        default:
                            r_next.seq = S_IDLE;
                    endcase
                S_SECOND:
                begin
                    r_next.seq = S_IDLE;
                    if (r_reg.cmd1 == CMD_PROGRAM)
                        req = 1'b1;
                    else if (code == CMD_CONFIRM)
                    begin
                        req = 1'b1;
                        case (r_reg.cmd1)
                            CMD_BLOCK_ERASE: rop = OP_ERASE;
                            CMD_ERASE_ALL:   rop = OP_ERASE_ALL;
                            CMD_LOCK_PROG:   rop = OP_LOCK_PROG;
                            default:         rop = OP_LOCK_READ;
                        endcase
                    end
                    else if (code == CMD_READ_ARRAY)
                        r_next.rmode = RM_ARRAY;
                    else
                        seq_bad = 1'b1;
                end
            endcase
        end

        if (req)
        begin
            if (rop != OP_LOCK_READ && (r_reg.prog_err || r_reg.erase_err))
                start = 1'b0;
            else if ((rop == OP_PROGRAM || rop == OP_ERASE) &&
                     f.addr_locked && !r_reg.lock_dis)
                locked_hit = 1'b1;
            else
            begin
                start = 1'b1;
                r_next.last_op = rop;
                if (!r_reg.resident && rop != OP_LOCK_READ)
                    r_next.rmode = RM_STATUS;
            end
        end

        if (clr_cmd)
        begin
            r_next.prog_err  = 1'b0;
            r_next.erase_err = 1'b0;
        end
        if (seq_bad)
        begin
            r_next.prog_err  = 1'b1;
            r_next.erase_err = 1'b1;
        end
        if (locked_hit)
        begin
            if (rop == OP_PROGRAM)
                r_next.prog_err = 1'b1;
            else
                r_next.erase_err = 1'b1;
        end
        // completion result is applied last so it outranks a clear
        if (f.done && f.fail)
        begin
            if (r_reg.last_op inside {OP_PROGRAM, OP_LOCK_PROG})
                r_next.prog_err = 1'b1;
            else
                r_next.erase_err = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign f.start    = start;
    assign f.op       = rop;
    assign f.addr     = widx;
    assign f.wdata    = i_pwdata[15:0];
    assign f.lock_dis = r_reg.lock_dis;
    assign f.raddr    = widx;

    assign o_prdata  = r_reg.prdata;
    assign o_pslverr = r_reg.pslverr;
    assign o_pready  = 1'b1;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_n);

    start_busy_a:
    assert property (start |=> !ready ##0 f.busy)
    else $error("ready flag not low after start");

    ready_done_a:
    assert property ($rose(ready) |-> f.done)
    else $error("ready flag rose without completion");

    busy_hold_a:
    assert property (f.busy |-> !start)
    else $error("operation started while busy");

    clear_errs_a:
    assert property (clr_cmd && !(f.done && f.fail)
        |=> !r_reg.prog_err && !r_reg.erase_err)
    else $error("clear status left an error flag");

    read_array_a:
    assert property (rom_wr && r_reg.seq == S_IDLE
        && code == CMD_READ_ARRAY |=> r_reg.rmode == RM_ARRAY)
    else $error("read array not entered");

    status_read_a:
    assert property (setup && hit_rom && r_reg.rewrite_en
        && r_reg.rmode == RM_STATUS
        |=> o_prdata == {24'h000000, $past(status_byte)})
    else $error("status byte not returned");

    err_refuse_a:
    assert property (req && rop != OP_LOCK_READ
        && (r_reg.prog_err || r_reg.erase_err) |-> !start)
    else $error("command taken while an error flag is set");

    seq_error_a:
    assert property (seq_bad |=> r_reg.prog_err && r_reg.erase_err)
    else $error("sequence error not flagged");

    locked_prog_a:
    assert property (locked_hit && rop == OP_PROGRAM
        |-> !start ##1 r_reg.prog_err)
    else $error("program on locked block not flagged");

    status_switch_a:
    assert property (start && !r_reg.resident && rop != OP_LOCK_READ
        |=> r_reg.rmode == RM_STATUS [*2])
    else $error("status mode not entered at start");

    prog_fail_a:
    assert property (f.done && f.fail && r_reg.last_op == OP_PROGRAM
        |=> r_reg.prog_err)
    else $error("program failure not flagged");

endmodule : flash_command_sequencer

// ===== flash_host_model.sv
`timescale 1ns/10ps
// Purpose: apb host standing in for the rewrite cpu
// Assumes: slave may add wait states
// Notes:   bench calls xfer; one idle edge between transfers
module flash_host_model
(
    // clock
    input  wire logic         i_clk,
    // apb master
    output logic              o_psel,
    output logic              o_penable,
    output logic              o_pwrite,
    output logic      [11:0]  o_paddr,
    output logic      [31:0]  o_pwdata,
    input  wire logic [31:0]  i_prdata,
    input  wire logic         i_pready
);
    initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;

    // rom accesses are whole aligned words
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_pwrite  <= w;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        q = i_prdata;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata  <= ~d;
    endtask : xfer
endmodule : flash_host_model

// ===== tb_flash_command_sequencer.sv
`timescale 1ns/10ps
// Purpose: self-checking bench for the flash command sequencer
// Assumes: short program and erase counts
// Notes:   host never stops clocks or enters flash-resident mode
module tb_flash_command_sequencer;
    import flash_seq_pkg::*;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        vfail = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic [31:0] seed = 32'h1a17;
    logic [15:0] d;
    int          n_fail = 0;
    int          checks_done = 0;

    flash_command_sequencer #(.PROG_CYCLES(8), .ERASE_CYCLES(8),
        .LOCK_CYCLES(8)) u_dut (.i_ref_clk(ref_clk), .i_resetn(resetn),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_verify_fail(vfail));
    flash_host_model u_host (.i_clk(ref_clk), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready));

    initial forever #20 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [11:0] rom(int w);
        return ROM_BASE + 12'(w * 4);
    endfunction : rom
    function automatic logic [31:0] fa(logic ee, logic pe, logic ld);
        fa = 32'h3;
        fa[ERASE_ERR_BIT] = ee;
        fa[PROG_ERR_BIT] = pe;
        fa[LOCK_DIS_BIT] = ld;
    endfunction : fa
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        u_host.xfer(1'b1, a, v, r);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        u_host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic cmd(input int w, input logic [7:0] c);
        r = rnd();
        wr(rom(w), {r[31:8], c});
    endtask : cmd
    task automatic wait_rdy;
        for (int k = 0; k < 100; k++)
        begin
            rd(CTRL_A_OFS);
            if (q[READY_BIT] === 1'b1)
                break;
        end
        check(q[READY_BIT], 1'b1);
    endtask : wait_rdy
    task automatic op(input logic [7:0] c, input int w);
        cmd(w, c);
        cmd(w, CMD_CONFIRM);
        wait_rdy();
    endtask : op
    task automatic stat(input logic [31:0] e);
        rd(CTRL_A_OFS);
        check(q, e);
        cmd(0, CMD_CLEAR_STATUS);
    endtask : stat
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(CTRL_A_OFS);
        check(q, 32'h1);
        check({31'h0, pready}, 32'h1);
        rd(12'h010);
        check({31'h0, pslverr}, 32'h1);
        wr(CTRL_A_OFS, 32'h2); // ram-resident only
        $display("test reset done");
        d = 16'(rnd());
        cmd(3, CMD_PROGRAM);
        wr(rom(3), {16'h0, d});
        rd(rom(3));
        check(q[7:0], 8'h00);
        wait_rdy();
        rd(rom(3));
        check(q[7:0], 8'h80);
        cmd(127, CMD_PROGRAM);
        wr(rom(127), {16'h0, d});
        wait_rdy();
        cmd(0, CMD_READ_ARRAY);
        rd(rom(3));
        check(q[15:0], d);
        $display("test program done");
        cmd(3, CMD_PROGRAM);
        wr(rom(3), {16'h0, ~d});
        wait_rdy();
        cmd(4, CMD_PROGRAM);
        wr(rom(4), {16'h0, d});
        cmd(0, CMD_READ_ARRAY);
        rd(rom(4));
        check(q[15:0], ERASED_WORD);
        rd(rom(3));
        check(q[15:0], d);
        stat(fa(0, 1, 0));
        cmd(0, CMD_READ_STATUS);
        rd(rom(9));
        check(q[7:0], 8'h80);
        op(CMD_LOCK_PROG, 31);
        op(CMD_LOCK_READ, 31);
        rd(CTRL_B_OFS);
        check(q[LOCK_RES_BIT], 1'b0);
        cmd(20, CMD_PROGRAM);
        wr(rom(20), {16'h0, d});
        wait_rdy();
        stat(fa(0, 1, 0));
        op(CMD_BLOCK_ERASE, 31);
        stat(fa(1, 0, 0));
        cmd(0, CMD_BLOCK_ERASE);
        cmd(31, 8'h33);
        stat(fa(1, 1, 0));
        cmd(0, CMD_READ_STATUS);
        cmd(0, CMD_BLOCK_ERASE);
        cmd(31, CMD_READ_ARRAY);
        rd(rom(31));
        check(q[15:0], ERASED_WORD);
        stat(fa(0, 0, 0));
        $display("test lock done");
        wr(CTRL_A_OFS, 32'h6);
        op(CMD_BLOCK_ERASE, 31);
        stat(fa(0, 0, 1));
        wr(CTRL_A_OFS, 32'h2);
        op(CMD_LOCK_READ, 31);
        rd(CTRL_B_OFS);
        check(q[LOCK_RES_BIT], 1'b1);
        vfail <= 1'b1;
        op(CMD_BLOCK_ERASE, 47);
        vfail <= 1'b0;
        stat(fa(1, 0, 0));
        op(CMD_BLOCK_ERASE, 47);
        stat(fa(0, 0, 0));
        op(CMD_ERASE_ALL, 0);
        cmd(0, CMD_READ_ARRAY);
        rd(rom(3));
        check(q[15:0], ERASED_WORD);
        rd(rom(127));
        check(q[15:0], d);
        $display("test erase done");
        complete_run();
    end
endmodule : tb_flash_command_sequencer
